// ===== rtl/acn_pkg.sv
// Purpose: Shared constants for the action command engine
// Assumes: Command blocks live in host memory, 32-bit words
// Notes: Offsets are byte offsets inside a command block
package acn_pkg;
    // Command word fields
    localparam int EOL_BIT = 31;
    localparam int SUSPEND_BIT = 30;
    localparam int INTR_BIT = 29;
    localparam int OPC_HI = 18;
    localparam int OPC_LO = 16;
    localparam int DONE_BIT = 15;
    localparam int OK_BIT = 13;
    // Opcodes
    localparam logic [2:0] OPC_NOP = 3'h0;
    localparam logic [2:0] OPC_ADDR = 3'h1;
    // Block layout and burst
    localparam logic [31:0] OFS_LINK = 32'h0000_0004;
    localparam logic [31:0] OFS_ADDR = 32'h0000_0008;
    localparam logic [2:0] BURST_WORDS = 3'h4;
    localparam logic [2:0] ADDR_BYTES = 3'h6;
    // Reset value of the station address
    localparam logic [47:0] ADDR_RESET = 48'hFFFF_FFFF_FFFF;
    // Control state codes
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_EXEC = 3'b010,
        ST_WAIT = 3'b011,
        ST_STATUS = 3'b100,
        ST_SUSP = 3'b101
    } acn_state_t;
endpackage

// ===== rtl/acn_addr_loader.sv
// Purpose: Byte machine that loads the station address register
// Assumes: Bytes arrive from the transmit FIFO, first wire byte first
// Notes: Raises done for one cycle after the sixth byte
`timescale 1ns/1ps
`default_nettype none
module acn_addr_loader (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic byte_ready,
    output logic [47:0] station_address,
    output logic done
);
    logic [47:0] addr_q, addr_d;
    logic [2:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Byte one lands in bits 7:0 so the low byte goes out first
    always_comb begin
        addr_d = addr_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start) begin
            busy_d = 1'b1;
            cnt_d = 3'h0;
        end else if (busy_q && byte_valid) begin
            addr_d[cnt_q*8 +: 8] = byte_data;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == acn_pkg::ADDR_BYTES - 3'h1) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    // Register stage
    // RULE16 - broadcast address at reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= acn_pkg::ADDR_RESET;
            cnt_q <= 3'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign byte_ready = busy_q;
    assign station_address = addr_q;
    assign done = done_q;
endmodule
`default_nettype wire

// ===== rtl/acn_cmd_unit.sv
// Purpose: Command unit executing no-op and station address setup
// Assumes: Simple word read/write memory port, same clock
// Notes: Other opcodes finish with the success flag clear
//
// Contract
// RULE1 - link plus base gives next address
// RULE2 - bit 31 marks last block
// RULE3 - last block sends unit idle
// RULE4 - idle move raises idle event
// RULE5 - bit 30 suspends, event if configured
// RULE6 - bit 29 alone raises done event
// RULE7 - host zeroes reserved bits 28:19
// RULE8 - opcode bits 18:16 select command
// RULE9 - host clears completion flag first
// RULE10 - device sets completion bit 15
// RULE11 - bit 13 set means no error
// RULE12 - no-op only fetches and chains
// RULE13 - no-op status has both flags set
// RULE14 - keep 48-bit station address register
// RULE15 - insert source only when skip clear
// RULE16 - reset loads all-ones address
// RULE17 - address bytes at 08h and 0Ch
// RULE18 - byte one is first on wire
// RULE19 - address goes via transmit DMA, FIFO
// RULE20 - start DMA at byte one, count six
// RULE21 - wait for byte machine finish
// RULE22 - fetch four words in one burst
// RULE23 - then update control block status
// RULE24 - address setup status both flags set
`timescale 1ns/1ps
`default_nettype none
module acn_cmd_unit (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start_req,
    input wire logic resume_req,
    input wire logic [31:0] unit_base,
    input wire logic [31:0] start_offset,
    input wire logic suspend_event_en,
    input wire logic skip_source_insert,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic mem_burst,
    input wire logic mem_gnt,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    output logic dma_start,
    output logic [31:0] dma_addr,
    output logic [2:0] dma_count,
    input wire logic fifo_valid,
    input wire logic [7:0] fifo_data,
    output logic fifo_ready,
    output logic [47:0] station_address,
    output logic [47:0] tx_source,
    output logic tx_source_insert,
    output logic [1:0] unit_state,
    output logic unit_idle_event,
    output logic unit_not_active_event,
    output logic command_done_event,
    output logic scb_status_update
);
    acn_pkg::acn_state_t state_q, state_d;
    logic [31:0] blk_q, blk_d;
    logic [31:0] next_q, next_d;
    logic [31:0] cmd_q, cmd_d;
    logic [2:0] rcnt_q, rcnt_d;
    logic issued_q, issued_d;
    logic ok_q, ok_d;
    logic idle_ev_q, idle_ev_d;
    logic na_ev_q, na_ev_d;
    logic done_ev_q, done_ev_d;
    logic scb_q, scb_d;
    logic dma_q, dma_d;
    logic addr_done;
    logic [2:0] opcode;

    // ------------------------------------------------------------
    // Command word decode
    // ------------------------------------------------------------
    // Saved word only, so host edits after the fetch are ignored
    // RULE8 - opcode field decode
    assign opcode = cmd_q[acn_pkg::OPC_HI:acn_pkg::OPC_LO];

    // ------------------------------------------------------------
    // Station address byte machine
    // ------------------------------------------------------------
    // RULE14 - one register for match and source
    acn_addr_loader u_loader (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(dma_q),
        .byte_valid(fifo_valid),
        .byte_data(fifo_data),
        .byte_ready(fifo_ready),
        .station_address(station_address),
        .done(addr_done)
    );

    // Skip gates the use only, the stored address stays intact
    // RULE15 - source used only with skip clear
    assign tx_source = station_address;
    assign tx_source_insert = !skip_source_insert;

    // ------------------------------------------------------------
    // Sequencer next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        blk_d = blk_q;
        next_d = next_q;
        cmd_d = cmd_q;
        rcnt_d = rcnt_q;
        issued_d = issued_q;
        ok_d = ok_q;
        idle_ev_d = 1'b0;
        na_ev_d = 1'b0;
        done_ev_d = 1'b0;
        scb_d = 1'b0;
        dma_d = 1'b0;
        unique case (state_q)
            acn_pkg::ST_IDLE, acn_pkg::ST_SUSP: begin
                // Start wins over resume when both arrive
                if (start_req) begin
                    // RULE1 - block address from base
                    blk_d = unit_base + start_offset;
                    state_d = acn_pkg::ST_FETCH;
                    rcnt_d = 3'h0;
                    issued_d = 1'b0;
                end else if (resume_req &&
                             state_q == acn_pkg::ST_SUSP) begin
                    blk_d = next_q;
                    state_d = acn_pkg::ST_FETCH;
                    rcnt_d = 3'h0;
                    issued_d = 1'b0;
                end
            end
            acn_pkg::ST_FETCH: begin
                // RULE22 - one four-word burst
                // Words are counted, the grant only ends the request
                if (mem_gnt) begin
                    issued_d = 1'b1;
                end
                if (mem_rvalid) begin
                    rcnt_d = rcnt_q + 3'h1;
                    if (rcnt_q == 3'h0) begin
                        cmd_d = mem_rdata;
                    end
                    if (rcnt_q == 3'h1) begin
                        // RULE1 - save next block address
                        next_d = unit_base + mem_rdata;
                    end
                    if (rcnt_q == acn_pkg::BURST_WORDS - 3'h1) begin
                        state_d = acn_pkg::ST_EXEC;
                    end
                end
            end
            acn_pkg::ST_EXEC: begin
                unique case (opcode)
                    // RULE12 - no-op just finishes
                    // RULE13 - no-op is successful
                    acn_pkg::OPC_NOP: begin
                        ok_d = 1'b1;
                        state_d = acn_pkg::ST_STATUS;
                        issued_d = 1'b0;
                    end
                    // RULE19 - address passes through DMA
                    // RULE20 - DMA from byte one
                    acn_pkg::OPC_ADDR: begin
                        dma_d = 1'b1;
                        state_d = acn_pkg::ST_WAIT;
                    end
                    default: begin
                        // Unknown opcodes complete with an error
                        ok_d = 1'b0;
                        state_d = acn_pkg::ST_STATUS;
                        issued_d = 1'b0;
                    end
                endcase
            end
            acn_pkg::ST_WAIT: begin
                // RULE21 - hold until register updated
                // No time limit: a stalled byte feed stalls the chain
                if (addr_done) begin
                    // RULE24 - setup reports success
                    ok_d = 1'b1;
                    state_d = acn_pkg::ST_STATUS;
                    issued_d = 1'b0;
                end
            end
            acn_pkg::ST_STATUS: begin
                // Events only once the status write is taken
                if (mem_gnt) begin
                    // RULE23 - control block status updated
                    scb_d = 1'b1;
                    // RULE6 - done event only with bit 29
                    done_ev_d = cmd_q[acn_pkg::INTR_BIT];
                    if (cmd_q[acn_pkg::EOL_BIT]) begin
                        // RULE2 - last block in chain
                        // RULE3 - unit goes idle
                        // RULE4 - idle move always signalled
                        state_d = acn_pkg::ST_IDLE;
                        idle_ev_d = 1'b1;
                    end else if (cmd_q[acn_pkg::SUSPEND_BIT]) begin
                        // RULE5 - suspend, event when enabled
                        state_d = acn_pkg::ST_SUSP;
                        na_ev_d = suspend_event_en;
                    end else begin
                        blk_d = next_q;
                        state_d = acn_pkg::ST_FETCH;
                        rcnt_d = 3'h0;
                    end
                end
            end
            default: begin
                // Illegal code falls back to idle
                state_d = acn_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= acn_pkg::ST_IDLE;
            blk_q <= 32'h0000_0000;
            next_q <= 32'h0000_0000;
            cmd_q <= 32'h0000_0000;
            rcnt_q <= 3'h0;
            issued_q <= 1'b0;
            ok_q <= 1'b0;
            idle_ev_q <= 1'b0;
            na_ev_q <= 1'b0;
            done_ev_q <= 1'b0;
            scb_q <= 1'b0;
            dma_q <= 1'b0;
        end else begin
            state_q <= state_d;
            blk_q <= blk_d;
            next_q <= next_d;
            cmd_q <= cmd_d;
            rcnt_q <= rcnt_d;
            issued_q <= issued_d;
            ok_q <= ok_d;
            idle_ev_q <= idle_ev_d;
            na_ev_q <= na_ev_d;
            done_ev_q <= done_ev_d;
            scb_q <= scb_d;
            dma_q <= dma_d;
        end
    end

    // ------------------------------------------------------------
    // Memory port
    // ------------------------------------------------------------
    // Read burst in fetch, single status write at the end
    // Address stays on the block, so status lands at offset 0
    always_comb begin
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_burst = 1'b0;
        mem_addr = blk_q;
        mem_wdata = 32'h0000_0000;
        if (state_q == acn_pkg::ST_FETCH && !issued_q) begin
            mem_req = 1'b1;
            mem_burst = 1'b1;
        end else if (state_q == acn_pkg::ST_STATUS) begin
            mem_req = 1'b1;
            mem_we = 1'b1;
            // RULE10 - completion flag set
            mem_wdata[acn_pkg::DONE_BIT] = 1'b1;
            // RULE11 - success flag per outcome
            mem_wdata[acn_pkg::OK_BIT] = ok_q;
            // Command half kept so the host sees its word intact
            mem_wdata[31:16] = cmd_q[31:16];
        end
    end

    // ------------------------------------------------------------
    // Transmit DMA request
    // ------------------------------------------------------------
    // RULE17 - address bytes start at offset 08h
    // RULE18 - byte one taken first
    assign dma_addr = blk_q + acn_pkg::OFS_ADDR;
    assign dma_count = acn_pkg::ADDR_BYTES;
    assign dma_start = dma_q;

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    // Coarse state: 0 idle, 1 suspended, 2 active
    assign unit_state = (state_q == acn_pkg::ST_IDLE) ? 2'h0 :
                        (state_q == acn_pkg::ST_SUSP) ? 2'h1 : 2'h2;
    assign unit_idle_event = idle_ev_q;
    assign unit_not_active_event = idle_ev_q | na_ev_q;
    assign command_done_event = done_ev_q;
    assign scb_status_update = scb_q;
endmodule
`default_nettype wire

// ===== tb/acn_cmd_asserts.sv
// Purpose: Port assertions for the command unit
// Assumes: One clock, async active-low reset
// Notes: Bound to every acn_cmd_unit instance
`timescale 1ns/1ps
`default_nettype none
module acn_cmd_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic skip_source_insert,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_burst,
    input wire logic mem_gnt,
    input wire logic dma_start,
    input wire logic [2:0] dma_count,
    input wire logic fifo_ready,
    input wire logic [47:0] station_address,
    input wire logic [47:0] tx_source,
    input wire logic tx_source_insert,
    input wire logic [1:0] unit_state,
    input wire logic unit_idle_event,
    input wire logic unit_not_active_event,
    input wire logic command_done_event,
    input wire logic scb_status_update
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Status write taken: the cycle after tells the world
    sequence wr_taken;
        mem_req && mem_we && mem_gnt;
    endsequence
    fetch_burst_a: assert property (mem_req && !mem_we |-> mem_burst)
        else $error("read without burst");
    status_done_a: assert property (
        mem_req && mem_we |-> mem_wdata[15])
        else $error("completion bit clear");
    // Both known opcodes must report success
    known_ok_a: assert property (
        mem_req && mem_we && mem_wdata[18:17] == 2'h0 |-> mem_wdata[13])
        else $error("known opcode without success");
    addr_reset_a: assert property ($rose(rst_n) |-> &station_address)
        else $error("address not all ones after reset");
    dma_count_a: assert property (dma_start |-> dma_count == 3'h6)
        else $error("dma count not six");
    source_insert_a: assert property (
        tx_source_insert == !skip_source_insert
        && tx_source == station_address)
        else $error("source insertion wrong");
    scb_update_a: assert property (wr_taken |=> scb_status_update)
        else $error("no control block update");
    done_event_a: assert property (
        wr_taken |=> command_done_event == $past(mem_wdata[29]))
        else $error("done event disagrees with flag");
    idle_move_a: assert property (
        mem_req && mem_we && mem_gnt && mem_wdata[31]
        |=> unit_idle_event && unit_not_active_event
        ##[0:1] unit_state == 2'h0)
        else $error("last block did not idle");
    fifo_start_a: assert property (dma_start |-> ##[0:2] fifo_ready)
        else $error("fifo never opened");
    byte_wait_a: assert property (
        fifo_ready |-> !(mem_req && mem_we))
        else $error("status before bytes done");
    cover property (dma_start);
    cover property (unit_idle_event);
    cover property (unit_not_active_event && !unit_idle_event);
endmodule
bind acn_cmd_unit acn_cmd_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .skip_source_insert(skip_source_insert), .mem_req(mem_req),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_burst(mem_burst),
    .mem_gnt(mem_gnt), .dma_start(dma_start), .dma_count(dma_count),
    .fifo_ready(fifo_ready), .station_address(station_address),
    .tx_source(tx_source), .tx_source_insert(tx_source_insert),
    .unit_state(unit_state), .unit_idle_event(unit_idle_event),
    .unit_not_active_event(unit_not_active_event),
    .command_done_event(command_done_event),
    .scb_status_update(scb_status_update));
`default_nettype wire

// ===== tb/acn_host_model.sv
// Purpose: Host memory and transmit DMA byte feeder
// Assumes: Word memory of 256 entries, bench fills blocks
// Notes: slow adds wait cycles before grants and bytes
`timescale 1ns/1ps
`default_nettype none
module acn_host_model (
    input wire logic core_clk,
    input wire logic [1:0] slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_gnt,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata,
    input wire logic dma_start,
    input wire logic [31:0] dma_addr,
    input wire logic fifo_ready,
    output logic fifo_valid,
    output logic [7:0] fifo_data
);
    logic [31:0] mem [0:255];
    logic [7:0] a;
    logic w;
    logic [47:0] sa;
    int k;
    int j;
    // Memory port; released data is inverted, never left stale
    // four word burst
    initial begin
        mem_gnt = 1'b0;
        mem_rvalid = 1'b0;
        mem_rdata = 32'h0;
        forever begin
            @(posedge core_clk);
            if (mem_req === 1'b1) begin
                a = mem_addr[9:2];
                repeat (slow) @(posedge core_clk);
                #2 mem_gnt = 1'b1;
                @(posedge core_clk);
                w = mem_we;
                if (w) mem[a] = mem_wdata;
                #2 mem_gnt = 1'b0;
                for (k = 0; k < 4 && !w; k++) begin
                    mem_rvalid = 1'b1;
                    mem_rdata = mem[a + k[7:0]];
                    @(posedge core_clk);
                    #2;
                end
                mem_rvalid = 1'b0;
                mem_rdata = ~mem_rdata;
            end
        end
    end
    // Transmit DMA: six bytes, held until taken
    // byte one first
    initial begin
        fifo_valid = 1'b0;
        fifo_data = 8'h0;
        forever begin
            @(posedge core_clk);
            if (dma_start === 1'b1) begin
                sa = {mem[dma_addr[9:2] + 8'h01][15:0], mem[dma_addr[9:2]]};
                for (j = 0; j < 6; j++) begin
                    repeat (slow) @(posedge core_clk);
                    #2 fifo_valid = 1'b1;
                    fifo_data = sa[8*j +: 8];
                    @(posedge core_clk);
                    while (fifo_ready !== 1'b1) @(posedge core_clk);
                    #2 fifo_valid = 1'b0;
                    fifo_data = ~fifo_data;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the command unit
// Assumes: Host model answers memory and DMA
// Notes: Reset check and row table first, then chained and odd cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [31:0] cmd;
        logic en;
        logic [15:0] st;
        logic [2:0] ev;
        logic [1:0] us;
    } acn_row_t;
    logic core_clk, rst_n, start_req, resume_req, suspend_event_en;
    logic skip_source_insert, mem_req, mem_we, mem_burst, mem_gnt;
    logic mem_rvalid, dma_start, fifo_valid, fifo_ready, tx_source_insert;
    logic unit_idle_event, unit_not_active_event, command_done_event;
    logic scb_status_update;
    logic [31:0] unit_base, start_offset, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] dma_addr;
    logic [2:0] dma_count, ev;
    logic [7:0] fifo_data;
    logic [47:0] station_address, tx_source;
    logic [1:0] unit_state, slow;
    int n_fail, comparisons, i;
    // Events {done, idle, not active}; status = C and OK bits
    acn_row_t rows [0:5] = '{
        {32'hA000_0000, 1'b0, 16'hA000, 3'h7, 2'h0},
        {32'h8000_0000, 1'b0, 16'hA000, 3'h3, 2'h0},
        {32'h8001_0000, 1'b0, 16'hA000, 3'h3, 2'h0},
        {32'h6000_0000, 1'b1, 16'hA000, 3'h5, 2'h1},
        {32'h4000_0000, 1'b0, 16'hA000, 3'h0, 2'h1},
        {32'hC002_0000, 1'b0, 16'h8000, 3'h3, 2'h0}};
    acn_cmd_unit uut (.core_clk(core_clk), .rst_n(rst_n),
        .start_req(start_req), .resume_req(resume_req),
        .unit_base(unit_base), .start_offset(start_offset),
        .suspend_event_en(suspend_event_en),
        .skip_source_insert(skip_source_insert), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_burst(mem_burst), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .dma_start(dma_start), .dma_addr(dma_addr),
        .dma_count(dma_count), .fifo_valid(fifo_valid),
        .fifo_data(fifo_data), .fifo_ready(fifo_ready),
        .station_address(station_address), .tx_source(tx_source),
        .tx_source_insert(tx_source_insert), .unit_state(unit_state),
        .unit_idle_event(unit_idle_event),
        .unit_not_active_event(unit_not_active_event),
        .command_done_event(command_done_event),
        .scb_status_update(scb_status_update));
    acn_host_model hm (.core_clk(core_clk), .slow(slow), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .dma_start(dma_start), .dma_addr(dma_addr), .fifo_ready(fifo_ready),
        .fifo_valid(fifo_valid), .fifo_data(fifo_data));
    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic tick;
        @(posedge core_clk);
        #2;
    endtask
    task automatic chk(input logic [47:0] g, input logic [47:0] e,
        input string m);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    // Start (rs low) or resume (rs high), collect events until n updates
    task automatic run(input logic [31:0] ofs, input int n, input logic rs);
        int t;
        ev = 3'h0;
        start_offset = ofs;
        start_req = !rs;
        resume_req = rs;
        tick();
        start_req = 1'b0;
        resume_req = 1'b0;
        for (t = 0; t < 400 && n > 0; t++) begin
            tick();
            ev = ev | {command_done_event, unit_idle_event,
                unit_not_active_event};
            if (scb_status_update === 1'b1) n--;
        end
        if (n > 0) chk(48'h0, 48'h1, "timeout");
        tick();
    endtask
    task automatic wrap_up;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        {rst_n, start_req, resume_req, suspend_event_en} = 4'h0;
        skip_source_insert = 1'b0;
        unit_base = 32'h0;
        start_offset = 32'h0;
        slow = 2'h0;
        repeat (4) @(posedge core_clk);
        #2 rst_n = 1'b1;
        tick();
        chk(station_address, acn_pkg::ADDR_RESET, "reset addr");
        chk(unit_state, 2'h0, "reset state");
        $display("reset test done");
        for (i = 0; i < 6; i++) begin
            hm.mem[8] = rows[i].cmd;
            hm.mem[9] = 32'h0;
            hm.mem[10] = 32'h0100_AA00;
            hm.mem[11] = 32'h0000_0302;
            suspend_event_en = rows[i].en;
            run(32'h20, 1, 1'b0);
            chk(hm.mem[8], {rows[i].cmd[31:16], rows[i].st}, "st");
            chk(ev, rows[i].ev, "events");
            chk(unit_state, rows[i].us, "state");
            $display("row %0d done", i);
        end
        chk(station_address, 48'h0302_0100_AA00, "wire order");
        // Chained no-op then address setup, slow host, nonzero base
        unit_base = 32'h100;
        slow = 2'h2;
        hm.mem[8'h50] = 32'h0000_0000;
        hm.mem[8'h51] = 32'h0000_0080;
        hm.mem[8'h60] = 32'hA001_0000;
        hm.mem[8'h61] = 32'h0;
        hm.mem[8'h62] = 32'h4433_2211;
        hm.mem[8'h63] = 32'h0000_6655;
        run(32'h40, 2, 1'b0);
        chk(hm.mem[8'h50], 32'h0000_A000, "nop status");
        chk(hm.mem[8'h60], 32'hA001_A000, "linked status");
        chk(station_address, 48'h6655_4433_2211, "addr");
        chk(tx_source, 48'h6655_4433_2211, "source");
        chk(ev, 3'h7, "chain events");
        $display("chain test done");
        // Suspend on a no-op, then resume into its linked block
        slow = 2'h1;
        suspend_event_en = 1'b1;
        hm.mem[8'h70] = 32'h4000_0000;
        hm.mem[8'h71] = 32'h0000_0100;
        hm.mem[8'h80] = 32'h8000_0000;
        hm.mem[8'h81] = 32'h0;
        run(32'hC0, 1, 1'b0);
        chk(unit_state, 2'h1, "suspended");
        chk(ev, 3'h1, "suspend event");
        run(32'h0, 1, 1'b1);
        chk(hm.mem[8'h80], 32'h8000_A000, "resumed status");
        chk(ev, 3'h3, "resume events");
        chk(unit_state, 2'h0, "resumed idle");
        $display("resume test done");
        // Reset while the unit is idle brings back the broadcast address
        rst_n = 1'b0;
        tick();
        chk(station_address, acn_pkg::ADDR_RESET, "mid reset addr");
        rst_n = 1'b1;
        tick();
        chk(unit_state, 2'h0, "mid reset state");
        $display("mid reset test done");
        skip_source_insert = 1'b1;
        tick();
        chk(tx_source_insert, 1'b0, "skip");
        $display("skip test done");
        wrap_up();
    end
endmodule
`default_nettype wire
